// file: design/amc_map.svh
// Constants of the audio mute controller: register indices, field
// positions, reset values and timing counts.
// Assumes a 40 MHz system clock and APB byte address = 4 * index.
//
// How it works
// - Auto unmute after delay unless disabled
// - Delay field matters only with auto unmute
// - Delay code zero unmutes at once
// - Delay codes give 250, 500, 750, 1000 ms
// - First mask: compressed, format, parity, clock
// - Second mask: PLLs, flatline, buffer under/overrun
// - Mute when regen packet misses a vsync
// - Mute on source avmute or link mode low
// - Mute when CTS drifts beyond tolerance
// - Mute when regen N value changes
// - Mute on stereo/multichannel layout switch
// - Mute on uncorrectable packet, port, no clock
// - Raw status shows live internal mute
// - Readback of last received source avmute
// - Pin enable puts mute on irq pin
// - Pin enable clear keeps irq pin low
// - Unmute needs conditions, auto, timer, in order
// - Force mute overrides all conditions
// - Manual unmute by toggling disable on, off
// - Speed field sets samples per ramp step
`ifndef AMC_MAP_SVH
`define AMC_MAP_SVH

// Register indices
`define AMC_IDX_AVSTAT 8'h04
`define AMC_IDX_SPEED 8'h0f
`define AMC_IDX_CTSTOL 8'h10
`define AMC_IDX_MASK1 8'h14
`define AMC_IDX_MASK2 8'h15
`define AMC_IDX_MASK3 8'h16
`define AMC_IDX_CTRL 8'h1a
`define AMC_IDX_PINCFG 8'h40
`define AMC_IDX_RAWSTAT 8'h65

// Field positions
`define AMC_BIT_AVMUTE 6
`define AMC_BIT_DLOVR 7
`define AMC_BIT_DLBYP 6
`define AMC_BIT_FORCE 4
`define AMC_WAIT_LSB 1
`define AMC_BIT_NOAUTO 0
`define AMC_BIT_RAWPIN 3
`define AMC_BIT_INTMUTE 6

// Writable bits of the mask registers
`define AMC_MASK1_RW 8'h33
`define AMC_MASK2_RW 8'heb
`define AMC_MASK3_RW 8'hff

// Reset values
`define AMC_RST_MASK1 8'h02
`define AMC_RST_MASK2 8'h00
`define AMC_RST_MASK3 8'h00
`define AMC_RST_CTRL 8'h00
`define AMC_RST_PINCFG 8'h00
`define AMC_RST_SPEED 5'h1f
`define AMC_RST_CTSTOL 6'h25

// Timing: one delay step of 250 ms at the system clock rate
`define AMC_CLK_HZ 40000000
`define AMC_STEP_MS 250
`define AMC_STEP_CYCLES (`AMC_STEP_MS * (`AMC_CLK_HZ / 1000))
`define AMC_MAX_STEPS 3'h4

`endif

// file: design/amc_pkg.sv
// Types shared by the audio mute controller files.
// Assumes nothing of its surroundings.
package amc_pkg;
  // Mute sequencer states
  typedef enum logic [1:0] {
    AMC_UNMUTED = 2'b00,
    AMC_MUTED = 2'b01,
    AMC_WAITING = 2'b10
  } amc_state_e;
endpackage

// file: design/amc_step_div.sv
// Divider giving a one-cycle pulse every delay step.
// Assumes clear is pulsed when a new delay starts.
`timescale 1ns/1ps
module amc_step_div #(
  parameter int STEP_CYCLES = 10000000
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic reset_n,
  // Control and pulse
  input wire logic clear,
  output logic stepTick
);
  logic [31:0] divCnt_reg; // Cycles since last step

  // Restarting on clear makes the first step a full period long
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      divCnt_reg <= 32'h0;
      stepTick <= 1'b0;
    end else if (clear) begin
      divCnt_reg <= 32'h0;
      stepTick <= 1'b0;
    end else if (divCnt_reg == 32'(STEP_CYCLES - 1)) begin
      divCnt_reg <= 32'h0;
      stepTick <= 1'b1;
    end else begin
      divCnt_reg <= divCnt_reg + 32'h1;
      stepTick <= 1'b0;
    end
  end
endmodule

// file: design/amc_unmute_timer.sv
// Counts delay steps down for the unmute delay.
// Assumes start is a one-cycle pulse and step ticks follow it.
`timescale 1ns/1ps
`include "amc_map.svh"
module amc_unmute_timer (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic reset_n,
  // Control
  input wire logic start,
  input wire logic [2:0] code,
  input wire logic stepTick,
  // Status
  output logic expired
);
  logic [2:0] stepCnt_reg; // Steps left

  // Codes above the longest delay are held at the longest
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      stepCnt_reg <= 3'h0;
    end else if (start) begin
      stepCnt_reg <= (code > `AMC_MAX_STEPS) ? `AMC_MAX_STEPS : code;
    end else if (stepTick && stepCnt_reg != 3'h0) begin
      stepCnt_reg <= stepCnt_reg - 3'h1;
    end
  end

  assign expired = (stepCnt_reg == 3'h0);
endmodule

// file: design/amc_mute_ctrl.sv
// Audio mute controller: mute conditions, masks, unmute sequencer,
// APB register slave and the mute pin.
// Assumes all link receiver inputs are synchronous to sys_clk.
`timescale 1ns/1ps
`include "amc_map.svh"
module amc_mute_ctrl #(
  parameter int STEP_CYCLES = `AMC_STEP_CYCLES
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic reset_n,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [9:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Format and sample status
  input wire logic compressedAudio,
  input wire logic formatChange,
  input wire logic sampleParityErr,
  input wire logic linkClockIrregular,
  input wire logic flatline,
  input wire logic bufferUnderrun,
  input wire logic bufferOverrun,
  input wire logic packetUncorrectable,
  // Lock and link status
  input wire logic audioPllLocked,
  input wire logic linkPllLocked,
  input wire logic linkClockPresent,
  input wire logic linkModeActive,
  input wire logic [1:0] inputPortSel,
  input wire logic channelMulti,
  input wire logic vsyncPulse,
  // General control packet
  input wire logic gcpValid,
  input wire logic gcpAvmute,
  // Clock regeneration packet
  input wire logic regenValid,
  input wire logic [19:0] regenCts,
  input wire logic [19:0] regenN,
  // Mute outputs
  output logic internalMute,
  output logic firstIrqPin,
  // Ramp and delay line settings
  output logic [4:0] muteSpeed,
  output logic delayLineManualOverride,
  output logic delayLineBypass
);
  // Software registers
  logic [7:0] maskFirst_reg;
  logic [7:0] maskSecond_reg;
  logic [7:0] maskThird_reg;
  logic [7:0] control_reg;
  logic [7:0] pinConfig_reg;
  logic [5:0] ctsTol_reg;
  // Condition tracking
  logic avmuteFlag_reg; // Avmute of last control packet
  logic regenSeen_reg; // Regen packet since last vsync
  logic regenMissing_reg; // A vsync period passed without one
  logic regenHave_reg; // A reference N/CTS is held
  logic [19:0] ctsRef_reg;
  logic [19:0] nRef_reg;
  logic layoutPrev_reg;
  logic [1:0] portPrev_reg;
  logic noAutoPrev_reg;
  // Sequencer
  amc_pkg::amc_state_e state_reg;
  logic timerStart_reg;
  // APB
  logic apbAccess; // Access phase of a transfer
  logic apbDone; // Edge at which the transfer completes
  logic [7:0] regIdx;
  // Derived conditions
  logic [19:0] ctsDiff;
  logic ctsDrift;
  logic nUpdate;
  logic layoutChange;
  logic portSwitch;
  logic [23:0] condAll;
  logic [23:0] maskAll;
  logic anyMute;
  logic forceMute;
  logic noAuto;
  logic [2:0] waitCode;
  logic manualRelease;
  logic stepTick;
  logic timerExpired;

  assign apbAccess = psel && penable;
  assign apbDone = apbAccess && pready;
  assign regIdx = paddr[9:2];
  assign forceMute = control_reg[`AMC_BIT_FORCE];
  assign noAuto = control_reg[`AMC_BIT_NOAUTO];
  assign waitCode = control_reg[`AMC_WAIT_LSB +: 3];

  // Register writes take effect only at the completing edge
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      maskFirst_reg <= `AMC_RST_MASK1;
      maskSecond_reg <= `AMC_RST_MASK2;
      maskThird_reg <= `AMC_RST_MASK3;
      control_reg <= `AMC_RST_CTRL;
      pinConfig_reg <= `AMC_RST_PINCFG;
      ctsTol_reg <= `AMC_RST_CTSTOL;
      muteSpeed <= `AMC_RST_SPEED;
      delayLineManualOverride <= 1'b0;
      delayLineBypass <= 1'b0;
    end else if (apbDone && pwrite) begin
      case (regIdx)
        // Mask registers keep only their defined bits
        `AMC_IDX_MASK1: maskFirst_reg <= pwdata[7:0] & `AMC_MASK1_RW;
        `AMC_IDX_MASK2: maskSecond_reg <= pwdata[7:0] & `AMC_MASK2_RW;
        `AMC_IDX_MASK3: maskThird_reg <= pwdata[7:0] & `AMC_MASK3_RW;
        `AMC_IDX_CTRL: control_reg <= pwdata[7:0] & 8'h1f;
        `AMC_IDX_PINCFG: pinConfig_reg <= pwdata[7:0] & 8'h08;
        `AMC_IDX_CTSTOL: ctsTol_reg <= pwdata[5:0];
        `AMC_IDX_SPEED: begin
          muteSpeed <= pwdata[4:0];
          delayLineManualOverride <= pwdata[`AMC_BIT_DLOVR];
          delayLineBypass <= pwdata[`AMC_BIT_DLBYP];
        end
        default: begin
          // Read-only and unmapped words ignore writes
        end
      endcase
    end
  end

  // One wait state: ready rises in the second access cycle
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0;
    end else if (apbAccess && !pready) begin
      pready <= 1'b1;
      pslverr <= 1'b0;
      prdata <= 32'h0;
      case (regIdx)
        `AMC_IDX_AVSTAT: prdata[`AMC_BIT_AVMUTE] <= avmuteFlag_reg;
        `AMC_IDX_SPEED: prdata[7:0] <= {delayLineManualOverride,
                                        delayLineBypass, 1'b0, muteSpeed};
        `AMC_IDX_CTSTOL: prdata[5:0] <= ctsTol_reg;
        `AMC_IDX_MASK1: prdata[7:0] <= maskFirst_reg;
        `AMC_IDX_MASK2: prdata[7:0] <= maskSecond_reg;
        `AMC_IDX_MASK3: prdata[7:0] <= maskThird_reg;
        `AMC_IDX_CTRL: prdata[7:0] <= control_reg;
        `AMC_IDX_PINCFG: prdata[7:0] <= pinConfig_reg;
        // Live mute state, no latching
        `AMC_IDX_RAWSTAT: prdata[`AMC_BIT_INTMUTE] <= internalMute;
        default: pslverr <= 1'b1; // Unmapped word
      endcase
    end else begin
      pready <= 1'b0;
      pslverr <= 1'b0;
    end
  end

  // Avmute flag follows each received control packet
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      avmuteFlag_reg <= 1'b0;
    end else if (gcpValid) begin
      avmuteFlag_reg <= gcpAvmute;
    end
  end

  // Missing regen packet: a whole vsync period without one
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      regenSeen_reg <= 1'b0;
      regenMissing_reg <= 1'b0;
    end else if (vsyncPulse) begin
      // A packet in the vsync cycle still counts for the ending period
      regenMissing_reg <= !(regenSeen_reg || regenValid);
      regenSeen_reg <= 1'b0;
    end else if (regenValid) begin
      regenSeen_reg <= 1'b1;
      regenMissing_reg <= 1'b0;
    end
  end

  // Reference N and CTS from the previous regen packet
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      regenHave_reg <= 1'b0;
      ctsRef_reg <= 20'h0;
      nRef_reg <= 20'h0;
    end else if (regenValid) begin
      regenHave_reg <= 1'b1;
      ctsRef_reg <= regenCts;
      nRef_reg <= regenN;
    end
  end

  // CTS drift beyond tolerance, N change
  assign ctsDiff = (regenCts > ctsRef_reg) ? regenCts - ctsRef_reg
                                           : ctsRef_reg - regenCts;
  assign ctsDrift = regenValid && regenHave_reg &&
                    (ctsDiff > {14'h0, ctsTol_reg});
  assign nUpdate = regenValid && regenHave_reg && (regenN != nRef_reg);

  // Previous layout, port and disable control for edge detection
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      layoutPrev_reg <= 1'b0;
      portPrev_reg <= 2'h0;
      noAutoPrev_reg <= 1'b0;
    end else begin
      layoutPrev_reg <= channelMulti;
      portPrev_reg <= inputPortSel;
      noAutoPrev_reg <= noAuto;
    end
  end

  // Either direction of layout change counts
  assign layoutChange = channelMulti != layoutPrev_reg;
  assign portSwitch = inputPortSel != portPrev_reg;

  // Condition vector lined up with the three mask registers
  always_comb begin
    condAll = 24'h0;
    condAll[5] = compressedAudio;
    condAll[4] = formatChange;
    condAll[1] = sampleParityErr;
    condAll[0] = linkClockIrregular;
    condAll[15] = !audioPllLocked;
    condAll[14] = !linkPllLocked;
    condAll[13] = regenMissing_reg;
    condAll[11] = flatline;
    condAll[9] = bufferUnderrun;
    condAll[8] = bufferOverrun;
    condAll[23] = avmuteFlag_reg;
    condAll[22] = !linkModeActive;
    condAll[21] = ctsDrift;
    condAll[20] = nUpdate;
    condAll[19] = layoutChange;
    condAll[18] = packetUncorrectable;
    condAll[17] = portSwitch;
    condAll[16] = !linkClockPresent;
  end

  // Cleared mask bits block their condition entirely
  assign maskAll = {maskThird_reg, maskSecond_reg, maskFirst_reg};
  assign anyMute = (|(condAll & maskAll)) || forceMute;

  // Disable control taken from 1 to 0 is the manual release
  assign manualRelease = noAutoPrev_reg && !noAuto;

  // Unmute sequencer; every release path requires no active condition
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      state_reg <= amc_pkg::AMC_UNMUTED;
      internalMute <= 1'b0;
      timerStart_reg <= 1'b0;
    end else begin
      timerStart_reg <= 1'b0;
      case (state_reg)
        amc_pkg::AMC_UNMUTED: begin
          if (anyMute) begin
            state_reg <= amc_pkg::AMC_MUTED;
            internalMute <= 1'b1;
          end
        end
        amc_pkg::AMC_MUTED: begin
          // Priority: conditions, then auto enable, then timer
          if (anyMute) begin
            state_reg <= amc_pkg::AMC_MUTED;
          end else if (manualRelease) begin
            state_reg <= amc_pkg::AMC_UNMUTED;
            internalMute <= 1'b0;
          end else if (noAuto) begin
            state_reg <= amc_pkg::AMC_MUTED;
          end else if (waitCode == 3'h0) begin
            state_reg <= amc_pkg::AMC_UNMUTED;
            internalMute <= 1'b0;
          end else begin
            // Delay timed from the moment conditions cleared
            state_reg <= amc_pkg::AMC_WAITING;
            timerStart_reg <= 1'b1;
          end
        end
        amc_pkg::AMC_WAITING: begin
          if (anyMute || noAuto) begin
            // A new condition or disabling auto unmute aborts the wait
            state_reg <= amc_pkg::AMC_MUTED;
          end else if (waitCode == 3'h0) begin
            state_reg <= amc_pkg::AMC_UNMUTED; // Cancelled
            internalMute <= 1'b0;
          end else if (timerExpired && !timerStart_reg) begin
            state_reg <= amc_pkg::AMC_UNMUTED;
            internalMute <= 1'b0;
          end
        end
        default: begin
          state_reg <= amc_pkg::AMC_MUTED;
          internalMute <= 1'b1;
        end
      endcase
    end
  end

  // Step divider, restarted with each delay
  amc_step_div #(
    .STEP_CYCLES(STEP_CYCLES)
  ) u_step_div (
    .sys_clk(sys_clk),
    .reset_n(reset_n),
    .clear(timerStart_reg),
    .stepTick(stepTick)
  );

  // Step countdown loaded from the delay code
  amc_unmute_timer u_unmute_timer (
    .sys_clk(sys_clk),
    .reset_n(reset_n),
    .start(timerStart_reg),
    .code(waitCode),
    .stepTick(stepTick),
    .expired(timerExpired)
  );

  // Mute pin; the processor downstream mutes on the high level
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      firstIrqPin <= 1'b0;
    end else begin
      firstIrqPin <= pinConfig_reg[`AMC_BIT_RAWPIN] && internalMute;
    end
  end

  // Cycles spent waiting, read only by the checks below
  logic [31:0] waitCyc_reg;
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      waitCyc_reg <= 32'h0;
    end else if (state_reg == amc_pkg::AMC_WAITING) begin
      waitCyc_reg <= waitCyc_reg + 32'h1;
    end else begin
      waitCyc_reg <= 32'h0;
    end
  end

  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!reset_n);

  // APB access phase still waiting for ready
  sequence s_apb_wait;
    psel && penable && !pready;
  endsequence

  sequence s_raw_read;
    psel && penable && pready && !pwrite && regIdx == `AMC_IDX_RAWSTAT;
  endsequence

  property p_apb_ready;
    s_apb_wait |=> pready ##1 !pready;
  endproperty
  a_apb_ready: assert property (p_apb_ready)
    else $error("APB ready not one wait state");

  property p_raw_status;
    s_raw_read |-> prdata[`AMC_BIT_INTMUTE] == $past(internalMute);
  endproperty
  a_raw_status: assert property (p_raw_status)
    else $error("Raw status differs from internal mute");

  property p_cond_mutes;
    anyMute |=> internalMute;
  endproperty
  a_cond_mutes: assert property (p_cond_mutes)
    else $error("Active condition did not mute");

  property p_force_holds;
    forceMute [*2] |-> internalMute;
  endproperty
  a_force_holds: assert property (p_force_holds)
    else $error("Force mute did not hold mute");

  property p_no_auto;
    internalMute && noAuto |=> internalMute;
  endproperty
  a_no_auto: assert property (p_no_auto)
    else $error("Unmuted while auto unmute disabled");

  property p_zero_delay;
    state_reg == amc_pkg::AMC_MUTED && !anyMute && !noAuto &&
      !manualRelease && waitCode == 3'h0 |=> !internalMute;
  endproperty
  a_zero_delay: assert property (p_zero_delay)
    else $error("Zero delay code did not unmute at once");

  property p_delay_min;
    $fell(internalMute) && $past(state_reg) == amc_pkg::AMC_WAITING &&
      $past(waitCode) != 3'h0 |->
      $past(waitCyc_reg) >= 32'(STEP_CYCLES);
  endproperty
  a_delay_min: assert property (p_delay_min)
    else $error("Unmuted before one delay step");

  property p_avmute;
    gcpValid && gcpAvmute && maskThird_reg[7] |=> ##1 internalMute;
  endproperty
  a_avmute: assert property (p_avmute)
    else $error("Source avmute did not mute");

  property p_regen_missing;
    vsyncPulse && !regenSeen_reg && !regenValid && maskSecond_reg[5]
      |=> ##1 internalMute;
  endproperty
  a_regen_missing: assert property (p_regen_missing)
    else $error("Missing regen packet did not mute");

  property p_port_switch;
    inputPortSel != $past(inputPortSel) && maskThird_reg[1]
      |=> internalMute;
  endproperty
  a_port_switch: assert property (p_port_switch)
    else $error("Port switch did not mute");

  property p_pin_on;
    pinConfig_reg[`AMC_BIT_RAWPIN] && internalMute |=> firstIrqPin;
  endproperty
  a_pin_on: assert property (p_pin_on)
    else $error("Mute not shown on pin");

  property p_pin_off;
    !pinConfig_reg[`AMC_BIT_RAWPIN] |=> !firstIrqPin;
  endproperty
  a_pin_off: assert property (p_pin_off)
    else $error("Pin driven while disabled");
endmodule

// file: dv/amc_audio_proc.sv
// Model of the downstream audio processor fed by the mute pin.
// Assumes the pin is synchronous to sys_clk and active high.
`timescale 1ns/1ps
module amc_audio_proc (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic reset_n,
  // Mute pin from the controller
  input wire logic muteIn,
  // Processor's own mute state
  output logic procMuted
);
  // One sync stage, as a real processor input would add
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      procMuted <= 1'b0;
    end else begin
      procMuted <= muteIn;
    end
  end
endmodule

// file: dv/tb_audio_mute_controller.sv
// Self-checking bench of the audio mute controller over APB.
// Assumes the design files and the processor model compile first.
`timescale 1ns/1ps
module tb_audio_mute_controller;
  localparam int STEP = 20; // Short delay step keeps the run brief
  // Bus and clock
  logic sys_clk, reset_n, psel, penable, pwrite, pready, pslverr, err;
  logic [9:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  // Level conditions, high = active; polarity fixed at the instance
  logic [11:0] cond;
  logic [1:0] inputPortSel;
  logic channelMulti, vsyncPulse, gcpValid, gcpAvmute, regenValid;
  logic [19:0] regenCts, regenN;
  logic internalMute, firstIrqPin, procMuted, dlOvr, dlByp;
  logic [4:0] muteSpeed;
  int miscompares, compares, n, lo;
  int cyc = 0;
  int cBit[12] = '{5, 4, 1, 0, 7, 6, 3, 1, 0, 6, 2, 0};
  int eBit[6] = '{1, 3, 7, 4, 5, 5};
  int rIdx[9] = '{'h04, 'h0f, 'h10, 'h14, 'h15, 'h16, 'h1a, 'h40, 'h65};
  int rVal[9] = '{0, 'h1f, 'h25, 2, 0, 0, 0, 0, 0};

  amc_mute_ctrl #(.STEP_CYCLES(STEP)) amc_mute_ctrl_inst (
    .sys_clk(sys_clk), .reset_n(reset_n), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .compressedAudio(cond[0]),
    .formatChange(cond[1]), .sampleParityErr(cond[2]),
    .linkClockIrregular(cond[3]), .audioPllLocked(~cond[4]),
    .linkPllLocked(~cond[5]), .flatline(cond[6]),
    .bufferUnderrun(cond[7]), .bufferOverrun(cond[8]),
    .linkModeActive(~cond[9]), .packetUncorrectable(cond[10]),
    .linkClockPresent(~cond[11]), .inputPortSel(inputPortSel),
    .channelMulti(channelMulti), .vsyncPulse(vsyncPulse),
    .gcpValid(gcpValid), .gcpAvmute(gcpAvmute),
    .regenValid(regenValid), .regenCts(regenCts), .regenN(regenN),
    .internalMute(internalMute), .firstIrqPin(firstIrqPin),
    .muteSpeed(muteSpeed), .delayLineManualOverride(dlOvr),
    .delayLineBypass(dlByp));

  amc_audio_proc amc_audio_proc_inst (
    .sys_clk(sys_clk), .reset_n(reset_n), .muteIn(firstIrqPin),
    .procMuted(procMuted));

  // 40 MHz clock
  initial begin
    sys_clk = 1'b0;
    forever #12.5 sys_clk = ~sys_clk;
  end

  // Hang guard: the tests need well under this many cycles
  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    if (cyc == 10000) begin
      miscompares++;
      results();
    end
  end

  task automatic results();
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] e, g);
    compares++;
    if (g !== e) begin
      miscompares++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic wt(input int c);
    repeat (c) @(posedge sys_clk);
  endtask

  // One APB transfer; request held until pready is seen at an edge
  task automatic apb(input logic w, input logic [7:0] idx,
                     input logic [31:0] d);
    @(posedge sys_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= {idx, 2'b00};
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    // No local limit: only the bench timeout ends a hung wait
    do begin
      @(posedge sys_clk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic rchk(input string nm, input logic [7:0] idx,
                      input logic [31:0] e);
    apb(1'b0, idx, 32'h0);
    chk(nm, e, rd);
  endtask

  // Clock regeneration packet, a one-cycle valid
  task automatic regen(input logic [19:0] c, input logic [19:0] v);
    regenCts <= c;
    regenN <= v;
    regenValid <= 1'b1;
    @(posedge sys_clk);
    regenValid <= 1'b0;
  endtask

  // One receiver event per kind
  task automatic evt(input int k);
    case (k)
      0: inputPortSel <= inputPortSel + 2'd1;
      1: channelMulti <= ~channelMulti;
      2: begin
        gcpAvmute <= 1'b1;
        gcpValid <= 1'b1;
        @(posedge sys_clk);
        gcpValid <= 1'b0;
      end
      3: regen(regenCts, regenN + 20'd1);
      4: begin
        regen(regenCts + 20'd37, regenN);
        wt(3);
        chk("cts tol", 0, internalMute);
        regen(regenCts + 20'd38, regenN);
      end
      default: repeat (3) begin
        vsyncPulse <= 1'b1;
        @(posedge sys_clk);
        vsyncPulse <= 1'b0;
        wt(5);
      end
    endcase
  endtask

  initial begin
    reset_n = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 10'h0;
    pwdata = 32'h0;
    cond = 12'h0;
    inputPortSel = 2'd0;
    channelMulti = 1'b0;
    vsyncPulse = 1'b0;
    gcpValid = 1'b0;
    gcpAvmute = 1'b0;
    regenValid = 1'b0;
    regenCts = 20'd1000;
    regenN = 20'd6144;
    miscompares = 0;
    compares = 0;
    repeat (2) @(posedge sys_clk);
    reset_n <= 1'b1;
    // Reset values of every register
    for (int i = 0; i < 9; i++) begin
      rchk("reset", rIdx[i][7:0], rVal[i]);
    end
    apb(1'b0, 8'h30, 32'h0);
    chk("slverr", 1, err);
    chk("unmapped", 0, rd);
    apb(1'b1, 8'h65, 32'hff);
    rchk("ro write", 8'h65, 32'h0);
    apb(1'b1, 8'h15, 32'hff);
    rchk("mask2 bits", 8'h15, 32'heb);
    apb(1'b1, 8'h15, 32'h0);
    // Host setup for a downstream processor doing the mute
    apb(1'b1, 8'h0f, 32'hc1);
    wt(1); // The write lands at the completing edge
    chk("speed", 1, muteSpeed);
    chk("dl ovr", 1, dlOvr);
    chk("dl byp", 1, dlByp);
    regen(regenCts, regenN); // First packet sets the baseline
    apb(1'b1, 8'h14, 32'h0); // Parity mask is set out of reset
    // Level conditions: ignored while masked, mute when unmasked
    for (int i = 0; i < 12; i++) begin
      lo = (i < 4) ? 'h14 : (i < 9) ? 'h15 : 'h16;
      cond[i] <= 1'b1;
      wt(3);
      chk("masked", 0, internalMute);
      apb(1'b1, lo[7:0], 32'h1 << cBit[i]);
      wt(2);
      chk("mute", 1, internalMute);
      chk("pin off", 0, firstIrqPin);
      rchk("raw", 8'h65, 32'h40);
      cond[i] <= 1'b0;
      wt(3);
      chk("unmute", 0, internalMute);
      apb(1'b1, lo[7:0], 32'h0);
    end
    // Events with auto unmute off and a delay code that must not act
    apb(1'b1, 8'h40, 32'h08);
    apb(1'b1, 8'h1a, 32'h07);
    for (int k = 0; k < 6; k++) begin
      apb(1'b1, (k == 5) ? 8'h15 : 8'h16, 32'h1 << eBit[k]);
      evt(k);
      wt(100);
      chk("latched", 1, internalMute);
      chk("pin", 1, firstIrqPin);
      chk("proc", 1, procMuted);
      if (k == 2) begin
        rchk("avmute", 8'h04, 32'h40);
      end
      apb(1'b1, 8'h15, 32'h0);
      apb(1'b1, 8'h16, 32'h0);
      apb(1'b1, 8'h1a, 32'h06);
      wt(3);
      chk("manual", 0, internalMute);
      apb(1'b1, 8'h1a, 32'h07);
    end
    // Forced mute, then delay codes 1 to 5 timed from the release
    for (int k = 1; k < 6; k++) begin
      apb(1'b1, 8'h1a, 32'h10 | (k << 1));
      wt(2);
      chk("force", 1, internalMute);
      apb(1'b1, 8'h1a, k << 1);
      n = 0;
      while (internalMute === 1'b1 && n < 200) begin
        @(posedge sys_clk);
        n++;
      end
      lo = STEP * ((k > 4) ? 4 : k);
      chk("delay", 1, (n >= lo && n <= lo + 8));
    end
    results();
  end
endmodule
